// file: common/ebm_pkg.sv
// constants for the serial-rom control bits and the pin function register
// assumes one clock domain and a register port with byte enables
// Function
// - the serial rom clock pin follows control bit 24, reset 0.
// - the serial rom select pin is high while control bit 25 is 1, reset 0.
// - control bit 26 drives the serial rom write data pin, reset 0.
// - reading control bit 27 returns the level of the serial rom read data pin.
// - control bit 28 reads 1 when a valid rom image was found.
// - writing 1 to bit 29 starts a reload that clears the bit when the rom read ends.
// - bits 24, 25, 26 and 29 are host written only; bits 27 and 28 are read only.
// - a pin field of 00 is plain input, 01 inverted input, 10 drive low, 11 drive high.
// - the field of pin n sits at bits 2n+1 down to 2n, pins 0 to 7.
// - pin fields reset to 00, load from the rom image and are host read and write.
// - with the mode straps at 01, pin 0 is held as a forced output.
// - with control bits 6:5 not 00, pin 1 is held as a forced output.
// - with control bit 7 set, pin 2 is a wake input whose polarity is pin field bit 4.
// - control bits 1:0 read back the mode strap levels.
// - control bit 7 clear blocks pin 2 from raising the wake event.
package ebm_pkg;
  localparam logic [7:0]  CTRL_OFFSET      = 8'h00;
  localparam logic [7:0]  PINCFG_OFFSET    = 8'h04;
  localparam int          BIT_ROM_CLOCK    = 24;
  localparam int          BIT_ROM_SELECT   = 25;
  localparam int          BIT_ROM_WDATA    = 26;
  localparam int          BIT_ROM_RDATA    = 27;
  localparam int          BIT_ROM_VALID    = 28;
  localparam int          BIT_RELOAD       = 29;
  localparam int          BIT_WAKE_ENABLE  = 7;
  localparam int          PDF_LSB          = 5;
  localparam int          PIN_COUNT        = 8;
  localparam int          SYNC_WIDTH       = 11;
  localparam logic [7:0]  CTRL_LOW_RESET   = 8'h00;
  localparam logic [7:0]  CTRL_LOW_MASK    = 8'hfc;
  localparam logic [15:0] PINCFG_RESET     = 16'h0000;
  localparam logic [1:0]  STRAP_PARALLEL   = 2'h1;
  localparam logic [1:0]  PDF_DISABLED     = 2'h0;
  typedef enum logic [0:0] {
    EBM_RELOAD_IDLE = 1'b0,
    EBM_RELOAD_BUSY = 1'b1
  } ebm_reload_e;
endpackage : ebm_pkg

// file: hdl/ebm_sync.sv
// three-stage input synchroniser with agreement filter
// assumes inputs are asynchronous to clk
`timescale 1ns/100ps
module ebm_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_sync_out;

  // a bit moves only once stages two and three agree, so one-cycle glitches are dropped
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_sync_out[i] = (stage2[i] == stage3[i]) ? stage3[i] : sync_out[i];
    end
  end

  // stage1 feeds stage2 and nothing else
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1   <= '0;
      stage2   <= '0;
      stage3   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      stage2   <= stage1;
      stage3   <= stage2;
      sync_out <= next_sync_out;
    end
  end
endmodule : ebm_sync

// file: hdl/ebm_config_regs.sv
// control register and pin function register with serial rom bit-bang pins
// assumes the register port and rom loader run on clk; pins are asynchronous
`timescale 1ns/100ps
module ebm_config_regs (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [3:0]  reg_be,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  input  wire logic [1:0]  mode_strap_pin,
  input  wire logic        serial_rom_read_data_pin,
  output logic             serial_rom_clock_pin,
  output logic             serial_rom_select_pin,
  output logic             serial_rom_write_data_pin,
  input  wire logic        rom_image_valid,
  input  wire logic        rom_load_strobe,
  input  wire logic [7:0]  rom_load_addr,
  input  wire logic [31:0] rom_load_data,
  input  wire logic        reload_done,
  output logic             reload_request,
  input  wire logic [7:0]  general_purpose_pin_in,
  output logic      [7:0]  general_purpose_pin_out,
  output logic      [7:0]  general_purpose_pin_oe,
  output logic      [7:0]  pin_input_level,
  output logic             wake_event_input,
  output logic      [7:0]  ctrl_low
);
  // true when a pin field selects one of the output modes
  function automatic logic field_drives(input logic [1:0] mode);
    field_drives = mode[1];
  endfunction : field_drives

  logic [10:0] sync_bits;
  logic [7:0]  pin_sync;
  logic [1:0]  strap_sync;
  logic        rom_di_sync;

  // every pin input passes the synchroniser before any use
  ebm_sync #(
    .WIDTH    (ebm_pkg::SYNC_WIDTH)
  ) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({serial_rom_read_data_pin, mode_strap_pin, general_purpose_pin_in}),
    .sync_out (sync_bits)
  );
  assign pin_sync    = sync_bits[7:0];
  assign strap_sync  = sync_bits[9:8];
  assign rom_di_sync = sync_bits[10];

  logic        host_ctrl_wr;
  logic        host_pin_wr;
  logic        load_ctrl;
  logic        load_pin;
  logic        reload_set;
  assign host_ctrl_wr = reg_wr && (reg_addr == ebm_pkg::CTRL_OFFSET);
  assign host_pin_wr  = reg_wr && (reg_addr == ebm_pkg::PINCFG_OFFSET);
  assign load_ctrl    = rom_load_strobe && (rom_load_addr == ebm_pkg::CTRL_OFFSET);
  assign load_pin     = rom_load_strobe && (rom_load_addr == ebm_pkg::PINCFG_OFFSET);
  assign reload_set   = host_ctrl_wr && reg_be[3] && reg_wdata[ebm_pkg::BIT_RELOAD];

  // stored register state
  logic [7:0]  next_ctrl_low;
  logic [15:0] pin_function_config;
  logic [15:0] next_pin_function_config;
  logic        next_rom_clock;
  logic        next_rom_select;
  logic        next_rom_wdata;
  logic        rom_valid;
  logic        next_rom_valid;

  // host writes win over a rom load in the same cycle; loads only touch loadable bits
  always_comb begin
    next_ctrl_low            = ctrl_low;
    next_pin_function_config = pin_function_config;
    next_rom_clock           = serial_rom_clock_pin;
    next_rom_select          = serial_rom_select_pin;
    next_rom_wdata           = serial_rom_write_data_pin;
    next_rom_valid           = rom_image_valid;
    if (load_ctrl) begin
      next_ctrl_low = rom_load_data[7:0] & ebm_pkg::CTRL_LOW_MASK;
    end
    if (load_pin) begin
      next_pin_function_config = rom_load_data[15:0];
    end
    if (host_ctrl_wr && reg_be[0]) begin
      next_ctrl_low = reg_wdata[7:0] & ebm_pkg::CTRL_LOW_MASK;
    end
    // rom pin bits come from the host alone, never from the image
    if (host_ctrl_wr && reg_be[3]) begin
      next_rom_clock  = reg_wdata[ebm_pkg::BIT_ROM_CLOCK];
      next_rom_select = reg_wdata[ebm_pkg::BIT_ROM_SELECT];
      next_rom_wdata  = reg_wdata[ebm_pkg::BIT_ROM_WDATA];
    end
    if (host_pin_wr && reg_be[0]) begin
      next_pin_function_config[7:0] = reg_wdata[7:0];
    end
    if (host_pin_wr && reg_be[1]) begin
      next_pin_function_config[15:8] = reg_wdata[15:8];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_low                  <= ebm_pkg::CTRL_LOW_RESET;
      pin_function_config       <= ebm_pkg::PINCFG_RESET;
      serial_rom_clock_pin      <= 1'b0;
      serial_rom_select_pin     <= 1'b0;
      serial_rom_write_data_pin <= 1'b0;
      rom_valid                 <= 1'b0;
    end else begin
      ctrl_low                  <= next_ctrl_low;
      pin_function_config       <= next_pin_function_config;
      serial_rom_clock_pin      <= next_rom_clock;
      serial_rom_select_pin     <= next_rom_select;
      serial_rom_write_data_pin <= next_rom_wdata;
      rom_valid                 <= next_rom_valid;
    end
  end

  // reload sequencer; a new request in the done cycle keeps it busy
  ebm_pkg::ebm_reload_e reload_state;
  ebm_pkg::ebm_reload_e next_reload_state;
  logic                 next_reload_request;

  always_comb begin
    next_reload_state = reload_state;
    case (reload_state)
      ebm_pkg::EBM_RELOAD_IDLE: begin
        if (reload_set) begin
          next_reload_state = ebm_pkg::EBM_RELOAD_BUSY;
        end
      end
      ebm_pkg::EBM_RELOAD_BUSY: begin
        if (reload_done && !reload_set) begin
          next_reload_state = ebm_pkg::EBM_RELOAD_IDLE;
        end
      end
      default: begin
        next_reload_state = ebm_pkg::EBM_RELOAD_IDLE;
      end
    endcase
    next_reload_request = (next_reload_state == ebm_pkg::EBM_RELOAD_BUSY);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reload_state   <= ebm_pkg::EBM_RELOAD_IDLE;
      reload_request <= 1'b0;
    end else begin
      reload_state   <= next_reload_state;
      reload_request <= next_reload_request;
    end
  end

  // pin decode, one field per pin at bits 2n+1:2n
  logic [7:0] next_pin_out;
  logic [7:0] next_pin_oe;
  logic [7:0] next_pin_level;
  logic [7:0] pin_forced;
  logic       wake_enable;
  logic       next_wake;

  assign wake_enable = ctrl_low[ebm_pkg::BIT_WAKE_ENABLE];
  // pins 0 and 1 are taken over by parallel port and power-down
  assign pin_forced[0] = (strap_sync == ebm_pkg::STRAP_PARALLEL);
  assign pin_forced[1] = (ctrl_low[ebm_pkg::PDF_LSB +: 2] != ebm_pkg::PDF_DISABLED);
  assign pin_forced[7:2] = 6'h00;

  genvar n;
  generate
    for (n = 0; n < ebm_pkg::PIN_COUNT; n++) begin : g_pin
      logic [1:0] mode;
      logic       wake_owned;
      assign mode       = pin_function_config[2*n +: 2];
      assign wake_owned = (n == 2) && wake_enable;
      // forced pins drive low; a wake pin is always an input
      assign next_pin_oe[n]    = !wake_owned && (pin_forced[n] || field_drives(mode));
      assign next_pin_out[n]   = !pin_forced[n] && field_drives(mode) && mode[0];
      assign next_pin_level[n] = pin_sync[n] ^ mode[0];
    end
  endgenerate

  // polarity of the wake input is field bit 4; disabled means no event
  assign next_wake = wake_enable && (pin_sync[2] ^ pin_function_config[4]);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      general_purpose_pin_out <= 8'h00;
      general_purpose_pin_oe  <= 8'h00;
      pin_input_level         <= 8'h00;
      wake_event_input        <= 1'b0;
    end else begin
      general_purpose_pin_out <= next_pin_out;
      general_purpose_pin_oe  <= next_pin_oe;
      pin_input_level         <= next_pin_level;
      wake_event_input        <= next_wake;
    end
  end

  // read data registered; unmapped offsets and reserved bits read zero
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = reg_rdata;
    if (reg_rd) begin
      next_rdata = 32'h0000_0000;
      if (reg_addr == ebm_pkg::CTRL_OFFSET) begin
        next_rdata[7:0]                     = ctrl_low;
        next_rdata[1:0]                     = strap_sync;
        next_rdata[ebm_pkg::BIT_ROM_CLOCK]  = serial_rom_clock_pin;
        next_rdata[ebm_pkg::BIT_ROM_SELECT] = serial_rom_select_pin;
        next_rdata[ebm_pkg::BIT_ROM_WDATA]  = serial_rom_write_data_pin;
        next_rdata[ebm_pkg::BIT_ROM_RDATA]  = rom_di_sync;
        next_rdata[ebm_pkg::BIT_ROM_VALID]  = rom_valid;
        next_rdata[ebm_pkg::BIT_RELOAD]     = reload_request;
      end else if (reg_addr == ebm_pkg::PINCFG_OFFSET) begin
        next_rdata[15:0] = pin_function_config;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // checks beside the logic they guard
  a_rom_clock_write: assert property (@(posedge clk) disable iff (!reset_n)
    (host_ctrl_wr && reg_be[3]) |=> (serial_rom_clock_pin == $past(reg_wdata[24])))
    else $error("rom clock pin did not follow bit 24");
  a_rom_select_write: assert property (@(posedge clk) disable iff (!reset_n)
    (host_ctrl_wr && reg_be[3]) |=> (serial_rom_select_pin == $past(reg_wdata[25])))
    else $error("rom select pin did not follow bit 25");
  a_rom_wdata_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !(host_ctrl_wr && reg_be[3]) |=> $stable(serial_rom_write_data_pin))
    else $error("rom write data changed without a host write");
  // the loader may answer in the very next cycle, so only the rise is checked here
  a_reload_sets: assert property (@(posedge clk) disable iff (!reset_n)
    reload_set |=> reload_request)
    else $error("reload request not raised by a write of one");
  a_reload_clears: assert property (@(posedge clk) disable iff (!reset_n)
    (reload_request && reload_done && !reload_set) |=> !reload_request)
    else $error("reload request not cleared after rom read");
  a_reload_idle: assert property (@(posedge clk) disable iff (!reset_n)
    (!reload_request && !reload_set) |=> !reload_request)
    else $error("reload request rose without a write of one");
  a_rdata_read: assert property (@(posedge clk) disable iff (!reset_n)
    (reg_rd && reg_addr == ebm_pkg::CTRL_OFFSET)
      |=> (reg_rdata[27] == $past(rom_di_sync)) && (reg_rdata[1:0] == $past(strap_sync)))
    else $error("read data pin or straps not returned");
  a_pin3_decode: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 (general_purpose_pin_oe[3] == $past(pin_function_config[7]))
      && (general_purpose_pin_out[3] == $past(pin_function_config[7] & pin_function_config[6])))
    else $error("pin 3 field decode wrong");
  a_pin0_forced: assert property (@(posedge clk) disable iff (!reset_n)
    (strap_sync == 2'h1) |=> general_purpose_pin_oe[0] && !general_purpose_pin_out[0])
    else $error("pin 0 not forced in parallel mode");
  a_pin1_forced: assert property (@(posedge clk) disable iff (!reset_n)
    (ctrl_low[6:5] != 2'h0) |=> general_purpose_pin_oe[1])
    else $error("pin 1 not forced in power-down mode");
  a_wake_gated: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 (wake_event_input == $past(ctrl_low[7] & (pin_sync[2] ^ pin_function_config[4]))))
    else $error("wake input gating or polarity wrong");
endmodule : ebm_config_regs

// file: test/ebm_rom_model.sv
// serial rom stand-in: echoes the last bit clocked in while selected
// assumes select, clock and write data come straight from the register block
`timescale 1ns/100ps
module ebm_rom_model (
  input  wire logic sclk,
  input  wire logic sel,
  input  wire logic din,
  output logic      dout
);
  logic last = 1'b0;
  // capture just after the rising clock; data was set up by an earlier write
  always @(posedge sclk) begin
    #1;
    if (sel) last = din;
  end
  // a deselected rom releases the line: show the inverse so stale data fails
  assign dout = sel ? last : ~last;
endmodule : ebm_rom_model

// file: test/tb_top.sv
// self-checking bench for the control and pin function registers
// assumes the register block talks to the rom model and the bench plays loader
`timescale 1ns/100ps
module tb_top;
  logic clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, rdi, sck, ssel, swd;
  logic rom_image_valid = 0, rom_load_strobe = 0, reload_done = 0, reload_request, wake;
  logic [7:0] reg_addr = 0, rom_load_addr = 0, gp_in = 0, gp_out, gp_oe, lvl, ctrl_low;
  logic [3:0] reg_be = 0;
  logic [31:0] reg_wdata = 0, rom_load_data = 0, reg_rdata, v, seed;
  logic [1:0] strap = 0, strap_m = 0;
  logic [7:0] ctrl_m = 0, pins_m = 0;
  logic [15:0] pcfg_m = 0;
  logic [2:0] hi_m = 0;
  logic last_m = 0, req_m = 0, valid_m = 0;
  int err_total = 0, comparisons = 0;
  always #12.5 clk = ~clk;
  ebm_config_regs i_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_be(reg_be),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .mode_strap_pin(strap), .serial_rom_read_data_pin(rdi), .serial_rom_clock_pin(sck),
    .serial_rom_select_pin(ssel), .serial_rom_write_data_pin(swd),
    .rom_image_valid(rom_image_valid), .rom_load_strobe(rom_load_strobe),
    .rom_load_addr(rom_load_addr), .rom_load_data(rom_load_data), .reload_done(reload_done),
    .reload_request(reload_request), .general_purpose_pin_in(gp_in),
    .general_purpose_pin_out(gp_out), .general_purpose_pin_oe(gp_oe),
    .pin_input_level(lvl), .wake_event_input(wake), .ctrl_low(ctrl_low));
  ebm_rom_model i_rom (.sclk(sck), .sel(ssel), .din(swd), .dout(rdi));
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  // one host access: request held for exactly the taking edge
  task automatic wr(logic [7:0] a, logic [3:0] be, logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_be <= be;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(logic [7:0] a, output logic [31:0] r);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    r = reg_rdata;
  endtask : rd
  task automatic ld(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    rom_load_addr <= a;
    rom_load_data <= d;
    rom_load_strobe <= 1'b1;
    @(posedge clk);
    rom_load_strobe <= 1'b0;
    #1;
  endtask : ld
  // model of the rom side: a rising clock while selected captures write data
  task automatic set_hi(logic [2:0] n);
    if (!hi_m[0] && n[0] && n[1]) last_m = n[2];
    hi_m = n;
  endtask : set_hi
  function automatic logic [31:0] exp_ctrl();
    logic rb;
    rb = hi_m[1] ? last_m : ~last_m;
    return {2'b00, req_m, valid_m, rb, hi_m, 16'h0000, ctrl_m[7:2], strap_m};
  endfunction : exp_ctrl
  task automatic chk_regs();
    rd(8'h00, v);
    chk("ctrl", v, exp_ctrl());
    rd(8'h04, v);
    chk("pincfg", v, {16'h0000, pcfg_m});
    chk("ctrl_low", ctrl_low, ctrl_m);
    chk("rom_pins", {swd, ssel, sck}, hi_m);
    chk("reload", reload_request, req_m);
  endtask : chk_regs
  task automatic chk_pins();
    logic [7:0] oe, out, lv;
    logic [1:0] f;
    for (int i = 0; i < 8; i++) begin
      f = pcfg_m[2*i +: 2];
      oe[i] = f[1];
      out[i] = f[0];
      lv[i] = pins_m[i] ^ f[0];
    end
    if (strap_m == 2'h1) {oe[0], out[0]} = 2'b10;
    if (ctrl_m[6:5] != 2'h0) {oe[1], out[1]} = 2'b10;
    if (ctrl_m[7]) oe[2] = 1'b0;
    chk("pin_oe", gp_oe, oe);
    chk("pin_out", gp_out & oe, out & oe);
    chk("pin_lvl", lvl, lv);
    chk("wake", wake, ctrl_m[7] & (pins_m[2] ^ pcfg_m[4]));
  endtask : chk_pins
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_sim();
  end
  initial begin
    seed = 32'hf1e3_26c7;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk_regs();
    chk_pins();
    // bit-bang a byte: select and data first, then the clock rise
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      wr(8'h00, 4'h8, {5'b1101_1, seed[0], 2'b10, 24'h0});
      set_hi({seed[0], 2'b10});
      wr(8'h00, 4'h8, {5'b0001_1, seed[0], 2'b11, 24'h0});
      set_hi({seed[0], 2'b11});
      repeat (5) @(posedge clk);
      chk_regs();
    end
    wr(8'h00, 4'h8, 32'h0000_0000);
    set_hi(3'h0);
    repeat (5) @(posedge clk);
    chk_regs();
    // random pin functions, overrides and reserved lanes
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      wr(8'h04, 4'h3, seed);
      pcfg_m = seed[15:0];
      seed = xs(seed);
      wr(8'h00, 4'h7, seed);
      ctrl_m = {seed[7:2], 2'b00};
      seed = xs(seed);
      @(posedge clk);
      gp_in <= seed[7:0];
      strap <= i[1:0];
      pins_m = seed[7:0];
      strap_m = i[1:0];
      repeat (8) @(posedge clk);
      #1;
      chk_pins();
      chk_regs();
    end
    // reload: request, image words, then the loader finishes
    wr(8'h00, 4'h8, 32'h2000_0000);
    req_m = 1'b1;
    chk_regs();
    seed = xs(seed);
    ld(8'h04, seed);
    pcfg_m = seed[15:0];
    seed = xs(seed);
    ld(8'h00, seed | 32'h0700_0000);
    ctrl_m = {seed[7:2], 2'b00};
    @(posedge clk);
    rom_image_valid <= 1'b1;
    valid_m = 1'b1;
    reload_done <= 1'b1;
    @(posedge clk);
    reload_done <= 1'b0;
    req_m = 1'b0;
    #1;
    chk("reload_done", reload_request, 1'b0);
    repeat (4) @(posedge clk);
    chk_regs();
    chk_pins();
    // unmapped place: write ignored, read gives zero
    wr(8'h08, 4'hf, 32'hffff_ffff);
    rd(8'h08, v);
    chk("unmapped", v, 32'h0000_0000);
    chk_regs();
    end_sim();
  end
endmodule : tb_top
